// File: ead_map.svh
//////////////////////////////////////////////////////////////////////////////
// Function
// - i mode memory refs are two words
// - no base names procedure base, zero low
// - v long form addresses like i mode
// - v short sector set adds pc low
// - v short sector clear picks stack/link base
// - r long cb bits choose stack or zero
// - r short: sector pc relative, else zero
// - three lookup memories, address from opcode and modal bits
// - one memory enabled onto shared outputs
// - four entry bits, sixteen microcode entries
// - nine addressing controls produced
// - decode address bits reused for ring weakening
// - decode in stage 4, registered at end
// - small displacement flag in s/r/v address
// - i mode addressing type field decoding
// - source zero means no index
// - dedicated flag for register/immediate forms
// - assist stalls front end
// - address formed stages 5 and 6
//////////////////////////////////////////////////////////////////////////////
`ifndef EAD_MAP_SVH
`define EAD_MAP_SVH

// opcode bits are numbered 1 (msb) to 16 (lsb)
`define EAD_OPB(n)          (16 - (n))
`define EAD_BIT_IND         1
`define EAD_BIT_XREG        2
`define EAD_BIT_SPC_A       4
`define EAD_BIT_SPC_B       5
`define EAD_BIT_SECTOR      7
`define EAD_BIT_TM_HI       10
`define EAD_BIT_TM_LO       11
`define EAD_BIT_SR_HI       12
`define EAD_BIT_SR_LO       14
`define EAD_BIT_BR_HI       15
`define EAD_BIT_BR_LO       16
`define EAD_SHORT_MSB       8
`define EAD_SHORT_SEL       8
`define EAD_SMALL_LIMIT     16'h0040

`define EAD_ENTRY_NONE      4'h0
`define EAD_ENTRY_IND32     4'h1
`define EAD_ENTRY_IND_V     4'h2
`define EAD_ENTRY_IND_SR    4'h3
`define EAD_ENTRY_STACK     4'h4
`define EAD_ENTRY_POST      4'h5
`define EAD_ENTRY_UNIMPL    4'hf

`define EAD_REG_CTRL        8'h00
`define EAD_REG_STATUS      8'h04
`define EAD_REG_EA          8'h08
`define EAD_REG_UNIMPL      8'h0c
`define EAD_REG_ASSIST      8'h10
`define EAD_CTRL_RESET      2'h1
`define EAD_RESP_OKAY       2'h0
`define EAD_RESP_SLVERR     2'h2

`endif

// File: ead_pkg.sv
package ead_pkg;

  typedef enum logic [2:0] {
    EAD_BASE_ZERO,
    EAD_BASE_PROC,
    EAD_BASE_STACK,
    EAD_BASE_LINK,
    EAD_BASE_EXTRA,
    EAD_BASE_PC,
    EAD_BASE_GREG
  } ead_base_type;

  typedef struct packed {
    logic         via_pointer;
    logic         two_word;
    logic         index_after;
    logic         index_before;
    logic         index_plain;
    logic         reg_or_immediate_flag;
    logic         address_trap_enable;
    logic         decode_addr_bit_a;
    logic         decode_addr_bit_b;
    logic         assist_request;
    logic         unimpl;
    logic [3:0]   entry;
    ead_base_type base_sel;
    logic [15:0]  disp;
  } ead_ctrl_type;

  typedef struct packed {
    ead_ctrl_type ctl4;
    logic         v4;
    logic         v5;
    logic         v6;
    logic         rr5;
    logic [15:0]  sum5;
    logic [15:0]  disp5;
    logic [15:0]  ea6;
    logic         stall;
    logic [1:0]   ctrl;
    logic [15:0]  unimpl_cnt;
    logic [15:0]  assist_cnt;
    logic         aw_got;
    logic [7:0]   aw_addr;
    logic         w_got;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } ead_state_type;

endpackage : ead_pkg

// File: ead_top.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`include "ead_map.svh"

module ead_top
  import ead_pkg::*;
(
  input  wire logic        clk,                   // pipeline clock
  input  wire logic        reset,                 // async reset, high
  input  wire logic        beat,                  // pipeline advance pulse
  input  wire logic        stage4_valid,          // instruction present in stage 4
  input  wire logic [15:0] opcode_word,           // first instruction word
  input  wire logic [15:0] second_word,           // second instruction word
  input  wire logic        addr_modal_bit_one,    // modal bit, mode msb
  input  wire logic        addr_modal_bit_two,    // modal bit, mode lsb
  input  wire logic        long_form,             // s/r/v two-word instruction
  input  wire logic        assist_done,           // decode step ends assist
  input  wire logic [15:0] stack_base_low,        // stack base low word
  input  wire logic [15:0] link_base_low,         // link base low word
  input  wire logic [15:0] extra_base_low,        // extra base low word
  input  wire logic [15:0] pc_low_word,           // program counter low word
  input  wire logic [15:0] general_reg_value,     // selected general register
  input  wire logic [15:0] index_value,           // selected index register
  output logic             via_pointer,           // indirect addressing
  output logic             two_word,              // instruction is long
  output logic             index_after_pointer_flag,  // post-indexed
  output logic             index_before_pointer_flag, // pre-indexed
  output logic             reg_or_immediate_flag, // register/immediate form
  output logic             address_trap_enable,   // address traps enabled
  output logic             decode_addr_bit_a,     // decode bit, ring weaken
  output logic             decode_addr_bit_b,     // decode bit, ring weaken
  output logic             assist_request,        // microcode assist wanted
  output logic [3:0]       entry_point,           // microcode entry
  output logic [1:0]       ring_weaken,           // to protection logic
  output logic             front_end_stall,       // hold front end
  output logic [2:0]       base_select,           // base register choice
  output logic [2:0]       register_select,       // general/index register
  output logic [15:0]      effective_address,     // stage 6 address
  output logic             address_valid,         // effective_address valid
  input  wire logic [7:0]  s_axi_awaddr,          // write address
  input  wire logic        s_axi_awvalid,         // write address valid
  output logic             s_axi_awready,         // write address ready
  input  wire logic [31:0] s_axi_wdata,           // write data
  input  wire logic [3:0]  s_axi_wstrb,           // write strobes
  input  wire logic        s_axi_wvalid,          // write data valid
  output logic             s_axi_wready,          // write data ready
  output logic [1:0]       s_axi_bresp,           // write response
  output logic             s_axi_bvalid,          // write response valid
  input  wire logic        s_axi_bready,          // write response ready
  input  wire logic [7:0]  s_axi_araddr,          // read address
  input  wire logic        s_axi_arvalid,         // read address valid
  output logic             s_axi_arready,         // read address ready
  output logic [31:0]      s_axi_rdata,           // read data
  output logic [1:0]       s_axi_rresp,           // read response
  output logic             s_axi_rvalid,          // read data valid
  input  wire logic        s_axi_rready           // read data ready
);

  ////////////////////////////////////////////////////////////////////////////
  // decode memories, kept as constant tables

  // s/r memory: {am1, am2, long, small, ind, cb15, cb16, sector}
  function automatic ead_ctrl_type ead_sr_mem(input logic [7:0] a);
    ead_ctrl_type c;
    c = '0;
    c.two_word      = a[5];
    c.via_pointer   = a[3];
    if (a[5]) begin
      if (a[2:1] == 2'h3) begin
        c.base_sel = EAD_BASE_STACK;
      end else begin
        c.base_sel = EAD_BASE_ZERO;
      end
    end else if (a[0]) begin
      c.base_sel = EAD_BASE_PC;
    end else begin
      c.base_sel = EAD_BASE_ZERO;
    end
    c.address_trap_enable = a[4] & ~a[5] & ~a[0];
    if (c.via_pointer) begin
      c.assist_request = 1'b1;
      c.entry          = `EAD_ENTRY_IND_SR;
    end else if (c.base_sel == EAD_BASE_STACK) begin
      c.assist_request = 1'b1;
      c.entry          = `EAD_ENTRY_STACK;
    end
    c.decode_addr_bit_a = c.entry[1];
    c.decode_addr_bit_b = c.entry[0];
    return c;
  endfunction : ead_sr_mem

  // v memory: {long, small, sector, ind, xreg, short_sel}
  function automatic ead_ctrl_type ead_v_mem(input logic [5:0] a);
    ead_ctrl_type c;
    c = '0;
    c.two_word    = a[5];
    c.via_pointer = a[2];
    c.index_plain = a[1] & ~a[2];
    c.index_after = a[1] & a[2];
    if (a[5]) begin
      c.base_sel = EAD_BASE_PROC;
    end else if (a[3]) begin
      c.base_sel = EAD_BASE_PC;
    end else begin
      c.base_sel = a[0] ? EAD_BASE_LINK : EAD_BASE_STACK;
      c.address_trap_enable = a[4];
    end
    if (c.via_pointer) begin
      c.assist_request = 1'b1;
      c.entry          = c.index_after ? `EAD_ENTRY_POST : `EAD_ENTRY_IND_V;
    end else if (c.base_sel == EAD_BASE_STACK) begin
      c.assist_request = 1'b1;
      c.entry          = `EAD_ENTRY_STACK;
    end
    c.decode_addr_bit_a = c.entry[2];
    c.decode_addr_bit_b = c.entry[0];
    return c;
  endfunction : ead_v_mem

  // i memory: {special, tm[1:0], sr[2:0], br[1:0]}
  function automatic ead_ctrl_type ead_i_mem(input logic [7:0] a);
    ead_ctrl_type c;
    logic         spc;
    logic [1:0]   tm;
    logic [2:0]   sr;
    logic [1:0]   br;
    logic         bad;
    c   = '0;
    spc = a[7];
    tm  = a[6:5];
    sr  = a[4:2];
    br  = a[1:0];
    bad = 1'b0;
    c.two_word = 1'b1;
    case (tm)
      2'h3, 2'h2: begin
        c.via_pointer    = 1'b1;
        c.index_after    = (tm == 2'h3) && (sr != 3'h0);
        c.index_before   = (tm == 2'h2) && (sr != 3'h0);
        c.assist_request = 1'b1;
        c.entry          = `EAD_ENTRY_IND32;
        c.address_trap_enable = 1'b1;
      end
      2'h1: begin
        c.index_plain = (sr != 3'h0);
        c.address_trap_enable = 1'b1;
      end
      default: begin
        c.reg_or_immediate_flag = 1'b1;
        c.base_sel = EAD_BASE_ZERO;
        case (br)
          2'h0: begin
            bad = spc;
            c.base_sel = EAD_BASE_GREG;
            {c.decode_addr_bit_a, c.decode_addr_bit_b} = 2'h1;
          end
          2'h1: begin
            bad = spc;
            {c.decode_addr_bit_a, c.decode_addr_bit_b} = (sr == 3'h0) ? 2'h3 : 2'h2;
          end
          2'h2: begin
            if (!spc || sr[2] || (sr == 3'h2)) begin
              bad = 1'b1;
            end else if (sr == 3'h0) begin
              {c.decode_addr_bit_a, c.decode_addr_bit_b} = 2'h3;
            end else begin
              c.base_sel = EAD_BASE_GREG;
              {c.decode_addr_bit_a, c.decode_addr_bit_b} = 2'h1;
            end
          end
          default: bad = 1'b1;
        endcase
      end
    endcase
    if (tm != 2'h0) begin
      case (br)
        2'h0:    c.base_sel = EAD_BASE_PROC;
        2'h1:    c.base_sel = EAD_BASE_STACK;
        2'h2:    c.base_sel = EAD_BASE_LINK;
        default: c.base_sel = EAD_BASE_EXTRA;
      endcase
      if (c.base_sel == EAD_BASE_STACK && !c.assist_request) begin
        c.assist_request = 1'b1;
        c.entry          = `EAD_ENTRY_STACK;
      end
    end
    if (bad) begin
      c       = '0;
      c.unimpl = 1'b1;
      c.entry  = `EAD_ENTRY_UNIMPL;
      c.decode_addr_bit_a = 1'b1;
    end
    return c;
  endfunction : ead_i_mem

  ////////////////////////////////////////////////////////////////////////////
  // decode address formation and memory selection

  logic [1:0]   mode;
  logic         small_displacement;
  logic [15:0]  short_disp;
  logic [15:0]  disp_sel;
  logic [7:0]   sr_addr;
  logic [5:0]   v_addr;
  logic [7:0]   i_addr;
  logic [2:0]   mem_en;
  ead_ctrl_type mem_out [3];
  ead_ctrl_type shared_bus;

  assign mode       = {addr_modal_bit_one, addr_modal_bit_two};
  assign short_disp = {{7{opcode_word[`EAD_SHORT_MSB]}}, opcode_word[8:0]};
  always_comb begin
    if (mode == 2'h3 || long_form) begin
      disp_sel = second_word;
    end else if (mode == 2'h2 && !opcode_word[`EAD_OPB(`EAD_BIT_SECTOR)]) begin
      disp_sel = {8'h00, opcode_word[7:0]};
    end else begin
      disp_sel = short_disp;
    end
  end
  assign small_displacement = (disp_sel < `EAD_SMALL_LIMIT);

  assign sr_addr = {addr_modal_bit_one, addr_modal_bit_two, long_form,
                    small_displacement,
                    opcode_word[`EAD_OPB(`EAD_BIT_IND)],
                    opcode_word[`EAD_OPB(`EAD_BIT_BR_HI)],
                    opcode_word[`EAD_OPB(`EAD_BIT_BR_LO)],
                    opcode_word[`EAD_OPB(`EAD_BIT_SECTOR)]};
  assign v_addr  = {long_form, small_displacement,
                    opcode_word[`EAD_OPB(`EAD_BIT_SECTOR)],
                    opcode_word[`EAD_OPB(`EAD_BIT_IND)],
                    opcode_word[`EAD_OPB(`EAD_BIT_XREG)],
                    opcode_word[`EAD_OPB(`EAD_SHORT_SEL)]};
  assign i_addr  = {opcode_word[`EAD_OPB(`EAD_BIT_SPC_A)]
                      & opcode_word[`EAD_OPB(`EAD_BIT_SPC_B)],
                    opcode_word[`EAD_OPB(`EAD_BIT_TM_HI):`EAD_OPB(`EAD_BIT_TM_LO)],
                    opcode_word[`EAD_OPB(`EAD_BIT_SR_HI):`EAD_OPB(`EAD_BIT_SR_LO)],
                    opcode_word[`EAD_OPB(`EAD_BIT_BR_HI):`EAD_OPB(`EAD_BIT_BR_LO)]};

  assign mem_en[0] = (mode == 2'h0) || (mode == 2'h1);
  assign mem_en[1] = (mode == 2'h2);
  assign mem_en[2] = (mode == 2'h3);

  // each memory gates its own word, the shared lines are the or of them
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_mem
      ead_ctrl_type raw;
      if (gi == 0) begin : g_sr
        assign raw = ead_sr_mem(sr_addr);
      end else if (gi == 1) begin : g_v
        assign raw = ead_v_mem(v_addr);
      end else begin : g_i
        assign raw = ead_i_mem(i_addr);
      end
      assign mem_out[gi] = mem_en[gi] ? raw : '0;
    end
  endgenerate

  always_comb begin
    shared_bus      = mem_out[0] | mem_out[1] | mem_out[2];
    shared_bus.disp = disp_sel;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pipeline stages and register slave

  ead_state_type s_q;
  ead_state_type s_d;
  logic [15:0]   base_val;
  logic          wr_fire;
  logic          rd_fire;
  logic          assist_set;
  logic [31:0]   rd_word;
  logic          rd_hit;
  logic          wr_hit;

  always_comb begin
    case (s_q.ctl4.base_sel)
      EAD_BASE_STACK: base_val = stack_base_low;
      EAD_BASE_LINK:  base_val = link_base_low;
      EAD_BASE_EXTRA: base_val = extra_base_low;
      EAD_BASE_PC:    base_val = pc_low_word;
      EAD_BASE_GREG:  base_val = general_reg_value;
      default:        base_val = 16'h0000;
    endcase
  end

  // writes wait for both channels; either may arrive first
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `EAD_REG_CTRL:   rd_word = {30'h0, s_q.ctrl};
      `EAD_REG_STATUS: rd_word = {16'h0, s_q.stall, s_q.v6, s_q.ctl4.entry,
                                  s_q.ctl4.via_pointer, s_q.ctl4.two_word,
                                  s_q.ctl4.index_after, s_q.ctl4.index_before,
                                  s_q.ctl4.reg_or_immediate_flag,
                                  s_q.ctl4.address_trap_enable,
                                  s_q.ctl4.decode_addr_bit_a,
                                  s_q.ctl4.decode_addr_bit_b,
                                  s_q.ctl4.assist_request, s_q.ctl4.unimpl};
      `EAD_REG_EA:     rd_word = {16'h0, s_q.ea6};
      `EAD_REG_UNIMPL: rd_word = {16'h0, s_q.unimpl_cnt};
      `EAD_REG_ASSIST: rd_word = {16'h0, s_q.assist_cnt};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (s_q.aw_addr)
      `EAD_REG_CTRL, `EAD_REG_STATUS, `EAD_REG_EA,
      `EAD_REG_UNIMPL, `EAD_REG_ASSIST: wr_hit = 1'b1;
      default:                          wr_hit = 1'b0;
    endcase
  end

  // stage 4 captures only while the front end runs
  // a forced assist stalls too, so the sequencer never runs with the front end live
  assign assist_set = beat && stage4_valid && !s_q.stall
                      && (shared_bus.assist_request || s_q.ctrl[1]);

  always_comb begin
    s_d = s_q;
    if (beat && !s_q.stall) begin
      s_d.v4 = stage4_valid;
      if (stage4_valid) begin
        s_d.ctl4 = shared_bus;
        if (s_q.ctrl[1]) begin
          s_d.ctl4.assist_request = 1'b1;
        end
        if (shared_bus.unimpl) begin
          s_d.unimpl_cnt = s_q.unimpl_cnt + 16'h0001;
        end
      end
    end
    if (beat) begin
      // stage 5: base plus index, sum recomputed on every beat even while stalled
      s_d.v5    = s_q.v4 && !s_q.stall;
      s_d.rr5   = s_q.ctl4.reg_or_immediate_flag && (s_q.ctl4.base_sel == EAD_BASE_GREG);
      s_d.disp5 = s_q.ctl4.disp;
      s_d.sum5  = base_val + ((s_q.ctl4.index_before || s_q.ctl4.index_plain)
                              ? index_value : 16'h0000);
      // stage 6: displacement added, post index left to phase two
      s_d.v6 = s_q.v5;
      if (s_q.v5) begin
        s_d.ea6 = s_q.rr5 ? s_q.sum5 : s_q.sum5 + s_q.disp5;
      end
    end
    // the done pulse always clears the stall; a new request waits until it is low
    s_d.stall = (s_q.stall && !assist_done) || assist_set;
    if (assist_set) begin
      s_d.assist_cnt = s_q.assist_cnt + 16'h0001;
    end

    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = wr_hit ? `EAD_RESP_OKAY : `EAD_RESP_SLVERR;
      if (s_q.aw_addr == `EAD_REG_CTRL && s_q.w_strb[0]) begin
        s_d.ctrl = s_q.w_data[1:0];
      end
      // counters clear on write, but a same-cycle count still lands
      if (s_q.aw_addr == `EAD_REG_UNIMPL && s_q.w_strb[0]) begin
        s_d.unimpl_cnt = (s_d.unimpl_cnt != s_q.unimpl_cnt) ? 16'h0001 : 16'h0000;
      end
      if (s_q.aw_addr == `EAD_REG_ASSIST && s_q.w_strb[0]) begin
        s_d.assist_cnt = assist_set ? 16'h0001 : 16'h0000;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = rd_hit ? `EAD_RESP_OKAY : `EAD_RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q      <= '0;
      s_q.ctrl <= `EAD_CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign via_pointer               = s_q.ctl4.via_pointer;
  assign two_word                  = s_q.ctl4.two_word;
  assign index_after_pointer_flag  = s_q.ctl4.index_after;
  assign index_before_pointer_flag = s_q.ctl4.index_before;
  assign reg_or_immediate_flag     = s_q.ctl4.reg_or_immediate_flag;
  // software can mask traps without touching the tables
  assign address_trap_enable       = s_q.ctl4.address_trap_enable & s_q.ctrl[0];
  assign decode_addr_bit_a         = s_q.ctl4.decode_addr_bit_a;
  assign decode_addr_bit_b         = s_q.ctl4.decode_addr_bit_b;
  assign assist_request            = s_q.ctl4.assist_request && s_q.v4;
  assign entry_point               = s_q.ctl4.entry;
  assign ring_weaken               = {s_q.ctl4.decode_addr_bit_a,
                                      s_q.ctl4.decode_addr_bit_b};
  assign front_end_stall           = s_q.stall;
  assign base_select               = s_q.ctl4.base_sel;
  assign register_select           = opcode_word[`EAD_OPB(`EAD_BIT_SR_HI):
                                                 `EAD_OPB(`EAD_BIT_SR_LO)];
  assign effective_address         = s_q.ea6;
  assign address_valid             = s_q.v6;

  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready  = !s_q.w_got;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

endmodule : ead_top

// File: ead_top_properties.sv
module ead_top_properties (
  input wire logic       clk, // clock
  input wire logic       reset, // reset
  input wire logic       beat, // advance
  input wire logic       front_end_stall, // stall
  input wire logic       assist_done, // assist end
  input wire logic       assist_request, // assist
  input wire logic       via_pointer, // indirect
  input wire logic       reg_or_immediate_flag, // rr or imm
  input wire logic       decode_addr_bit_a, // bit a
  input wire logic       decode_addr_bit_b, // bit b
  input wire logic [3:0] entry_point, // entry
  input wire logic [1:0] ring_weaken, // ring
  input wire logic       address_valid // ea valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_RING: assert property (ring_weaken == {decode_addr_bit_a, decode_addr_bit_b})
    else $error("ring bits differ");
  AST_CLR: assert property (front_end_stall && assist_done |=> !front_end_stall)
    else $error("stall not cleared");
  AST_HOLD: assert property (front_end_stall && !assist_done |=> front_end_stall)
    else $error("stall dropped");
  AST_SET: assert property ($rose(front_end_stall) |-> $past(beat) && assist_request)
    else $error("stall without cause");
  AST_ENTRY: assert property ($changed(entry_point) |-> $past(beat))
    else $error("entry moved");
  AST_EA: assert property ($rose(address_valid) |-> $past(beat))
    else $error("address early");
  AST_UNIMPL: assert property (entry_point == 4'hf |-> decode_addr_bit_a && !via_pointer)
    else $error("unimpl controls");
  AST_RR: assert property (reg_or_immediate_flag |-> !via_pointer)
    else $error("rr with pointer");
  cover property ($rose(front_end_stall));
  cover property (entry_point == 4'hf);
  cover property ($rose(address_valid));
endmodule : ead_top_properties

// File: ead_seq_model.sv
module ead_seq_model (
  input wire logic       clk, // clock
  input wire logic       reset, // reset
  input wire logic       front_end_stall, // assist running
  input wire logic [3:0] slow, // assist length
  output logic           assist_done // decode step
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // one pulse per stall, so a late step never ends the next assist
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      assist_done <= 1'b0;
    end else begin
      assist_done <= front_end_stall && !assist_done && cnt_q == slow;
      cnt_q <= (front_end_stall && !assist_done) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : ead_seq_model

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, beat, stage4_valid, addr_modal_bit_one, addr_modal_bit_two, long_form;
  logic via_pointer, two_word, index_after_pointer_flag, index_before_pointer_flag;
  logic reg_or_immediate_flag, address_trap_enable, decode_addr_bit_a, decode_addr_bit_b;
  logic assist_request, front_end_stall, address_valid, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] opcode_word, second_word, stack_base_low, link_base_low, extra_base_low, s;
  logic [15:0] pc_low_word, general_reg_value, index_value, effective_address;
  logic [3:0]  entry_point, s_axi_wstrb, slow;
  logic [2:0]  base_select, register_select;
  logic [1:0]  ring_weaken, s_axi_bresp, s_axi_rresp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [33:0] r;
  wire         assist_done;
  int          fail_count, checks_done;
  ead_top u_ead_top (.*);
  ead_seq_model u_ead_seq_model (.clk, .reset, .front_end_stall, .slow, .assist_done);
  always #5 clk = ~clk;
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [2:0] t;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {{3{w}}, {2{!w}}};
    do begin
      @(negedge clk);
      t = w ? {s_axi_awready, s_axi_wready, s_axi_bvalid} : {s_axi_arready, 1'b0, s_axi_rvalid};
      r = {w ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
      @(posedge clk);
      if (t[2]) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (t[1]) s_axi_wvalid <= 1'b0;
    end while (!t[0]);
    {s_axi_bready, s_axi_rready} <= 2'h0;
    @(posedge clk);
  endtask : ax
  task automatic run(input logic [17:0] m, input logic [15:0] ex, input logic [15:0] ea);
    int n;
    {addr_modal_bit_one, addr_modal_bit_two, opcode_word} <= m;
    beat <= 1'b1;
    slow <= 4'($urandom);
    @(posedge clk);
    beat <= 1'b0;
    @(negedge clk);
    chk({ring_weaken, assist_request, address_trap_enable, two_word, base_select, via_pointer,
         index_after_pointer_flag, index_before_pointer_flag, reg_or_immediate_flag,
         entry_point}, ex);
    chk(register_select, m[4:2]);
    for (n = 0; n < 40 && front_end_stall; n++) @(negedge clk);
    chk(front_end_stall, 34'h0);
    @(posedge clk);
    // a plain direct word follows; only a forced assist stalls on it
    {addr_modal_bit_one, addr_modal_bit_two, opcode_word} <= {2'h3, 16'h0020};
    beat <= 1'b1;
    repeat (2) @(posedge clk);
    beat <= 1'b0;
    @(negedge clk);
    if (ex[3:0] == 4'h0) chk({address_valid, effective_address}, {1'b1, ea});
    @(posedge clk);
    $display("test %h end", m);
  endtask : run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(78113));
    {second_word, stack_base_low, link_base_low, extra_base_low, pc_low_word,
     general_reg_value, index_value} = 112'({$urandom, $urandom, $urandom, $urandom});
    {clk, beat, long_form, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata, opcode_word} = '0;
    {addr_modal_bit_one, addr_modal_bit_two, stage4_valid, s_axi_wstrb, reset} = 8'h3f;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    ax(1'b0, 8'h00, 32'h0);
    chk(r, 34'h000000001);
    ax(1'b0, 8'h20, 32'h0);
    chk(r, 34'h200000000);
    ax(1'b1, 8'h00, 32'h1);
    chk(r[33:32], 34'h0);
    run({2'h3, 16'h0020}, 16'h1900, second_word);
    run({2'h3, 16'h0008}, 16'h4e10, general_reg_value);
    run({2'h3, 16'h000a}, 16'h800f, 16'h0);
    run({2'h3, 16'h0060}, 16'h3981, 16'h0);
    s = 16'($urandom % 7 + 1) << 2;
    run({2'h3, 16'h0060 | s}, 16'h39c1, 16'h0);
    run({2'h3, 16'h0040 | s}, 16'h39a1, 16'h0);
    for (int k = 1; k < 3; k++) begin
      s = 16'($urandom % 512);
      run({k[1:0], 16'h0200 | s}, 16'h0500, pc_low_word + {{7{s[8]}}, s[8:0]});
    end
    ax(1'b0, 8'h0c, 32'h0);
    chk(r, 34'h000000001);
    ax(1'b0, 8'h10, 32'h0);
    chk(r, 34'h000000003);
    ax(1'b1, 8'h00, 32'h2);
    ax(1'b0, 8'h00, 32'h0);
    chk(r, 34'h000000002);
    run({2'h3, 16'h0020}, 16'h2900, second_word);
    wrap_up;
  end
  initial begin
    #100us;
    fail_count++;
    wrap_up;
  end
endmodule : tb_top
bind ead_top ead_top_properties u_ead_top_properties (.clk, .reset, .beat, .front_end_stall,
  .assist_done, .assist_request, .via_pointer, .reg_or_immediate_flag, .decode_addr_bit_a,
  .decode_addr_bit_b, .entry_point, .ring_weaken, .address_valid);
